// file: rtl/jif_flash_engine.sv
// indirect register engine: control, data, address, scale and the flash array
// assumes start pulses come from the port logic on the same clock
module jif_flash_engine import jif_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire jif_req_type req,
    output jif_rsp_type rsp
);
    typedef struct packed {
        jif_eng_type eng;
        jif_req_type op;
        logic [7:0] cnt;
        logic [8:0] ecnt;
        logic busy;
        logic [PAY_W-1:0] result;
        logic [7:0] ctrl;
        logic [7:0] data;
        logic [15:0] addr;
        logic [7:0] scale;
    } jif_eng_state_type;

    localparam jif_eng_state_type ST_RST = '{eng: ENG_IDLE, op: '0, cnt: '0, ecnt: '0,
        busy: 1'b0, result: '0, ctrl: CTRL_RESET, data: '0, addr: '0, scale: SCALE_RESET};

    logic [7:0] mem [FLASH_BYTES];
    jif_eng_state_type st_ff, nxt_st;
    logic we;
    logic [FLASH_AW-1:0] wa;
    logic [7:0] wd;
    logic [7:0] mem_rd;
    logic [7:0] pl_byte;
    logic done;

    assign mem_rd = mem[st_ff.addr[FLASH_AW-1:0]];
    assign pl_byte = st_ff.op.payload[PAY_W-1:BYTE_LSB];
    assign done = (st_ff.eng == ENG_WAIT) && (st_ff.cnt == 8'h00);
    assign rsp = '{busy: st_ff.busy, result: st_ff.result};

    // ------------------------------------------------------------
    // operation sequencing
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        we = 1'b0;
        wa = st_ff.addr[FLASH_AW-1:0];
        wd = pl_byte;
        case (st_ff.eng)
            ENG_IDLE: begin
                // a start while busy cannot happen here, so idle is the only taker
                if (req.start) begin
                    nxt_st.op = req;
                    nxt_st.busy = 1'b1;
                    nxt_st.cnt = st_ff.scale;
                    nxt_st.eng = ENG_WAIT;
                end
            end
            ENG_WAIT: begin
                if (done) begin
                    nxt_st.busy = 1'b0;
                    nxt_st.eng = ENG_IDLE;
                    case (st_ff.op.sel)
                        SEL_CTRL: begin
                            if (st_ff.op.wr) begin
                                nxt_st.ctrl = pl_byte;
                            end else begin
                                nxt_st.result = {10'h000, st_ff.ctrl};
                            end
                        end
                        SEL_ADDR: begin
                            if (st_ff.op.wr) begin
                                nxt_st.addr = st_ff.op.payload[PAY_W-1:ADDR_LSB];
                            end else begin
                                nxt_st.result = {2'b00, st_ff.addr};
                            end
                        end
                        SEL_SCALE: begin
                            if (st_ff.op.wr) begin
                                nxt_st.scale = pl_byte;
                            end else begin
                                nxt_st.result = {10'h000, st_ff.scale};
                            end
                        end
                        default: begin
                            if (st_ff.op.wr) begin
                                nxt_st.data = pl_byte;
                                case (st_ff.ctrl[7:WM_LSB])
                                    WM_PROGRAM: begin
                                        we = 1'b1;
                                        nxt_st.addr = st_ff.addr + 16'h0001;
                                    end
                                    WM_ERASE: begin
                                        // wrong key leaves the array untouched
                                        if (pl_byte == ERASE_KEY) begin
                                            nxt_st.busy = 1'b1;
                                            nxt_st.ecnt = 9'h000;
                                            nxt_st.eng = ENG_ERASE;
                                        end
                                    end
                                    default: begin
                                    end
                                endcase
                            end else begin
                                case (st_ff.ctrl[WM_LSB-1:0])
                                    RM_FETCH: begin
                                        nxt_st.data = mem_rd;
                                        nxt_st.result = {10'h000, mem_rd};
                                    end
                                    RM_FETCH_INC: begin
                                        nxt_st.data = mem_rd;
                                        nxt_st.result = {10'h000, mem_rd};
                                        nxt_st.addr = st_ff.addr + 16'h0001;
                                    end
                                    default: begin
                                        nxt_st.result = {10'h000, st_ff.data};
                                    end
                                endcase
                            end
                        end
                    endcase
                end else begin
                    nxt_st.cnt = st_ff.cnt - 8'h01;
                end
            end
            ENG_ERASE: begin
                // one byte per cycle keeps the array a plain single-port memory
                we = 1'b1;
                wa = {st_ff.addr[FLASH_AW-1:9], st_ff.ecnt};
                wd = ERASED_BYTE;
                nxt_st.ecnt = st_ff.ecnt + 9'h001;
                if (st_ff.ecnt == SECTOR_LAST) begin
                    nxt_st.busy = 1'b0;
                    nxt_st.eng = ENG_IDLE;
                end
            end
            default: begin
                nxt_st = ST_RST;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state and array
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // array holds no reset, like the flash it stands for
    always_ff @(posedge clk) begin
        if (we) begin
            mem[wa] <= wd;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_done_data_wr;
        done && st_ff.op.wr && st_ff.op.sel == SEL_DATA;
    endsequence

    chk_busy_raise: assert property (req.start && !rsp.busy |=> rsp.busy)
        else $error("busy not raised on launch");
    chk_busy_drop: assert property (done && st_ff.op.sel != SEL_DATA |=> !rsp.busy)
        else $error("busy not dropped at completion");
    chk_ctrl_write: assert property (done && st_ff.op.wr && st_ff.op.sel == SEL_CTRL
        |=> st_ff.ctrl == $past(pl_byte))
        else $error("control write lost");
    chk_prog_incr: assert property (s_done_data_wr ##0 st_ff.ctrl[7:WM_LSB] == WM_PROGRAM
        |=> st_ff.addr == $past(st_ff.addr) + 16'h0001)
        else $error("address not advanced after program");
    chk_erase_key: assert property (s_done_data_wr ##0 st_ff.ctrl[7:WM_LSB] == WM_ERASE
        ##0 pl_byte != ERASE_KEY |=> st_ff.eng == ENG_IDLE)
        else $error("erase ran without key");
    chk_fetch_read: assert property (done && !st_ff.op.wr && st_ff.op.sel == SEL_DATA
        && st_ff.ctrl[WM_LSB-1:0] == RM_FETCH |=> rsp.result == {10'h000, $past(mem_rd)})
        else $error("fetched byte not returned");
endmodule // jif_flash_engine

// file: rtl/jif_pkg.sv
// shared constants and types of the flash access port behind the test port
// assumes one core clock domain; the test port pins arrive unsynchronised
package jif_pkg;
    // ------------------------------------------------------------
    // instruction codes and widths
    // ------------------------------------------------------------
    localparam int IR_W = 16;
    localparam int DR_W = 20;
    localparam int PAY_W = 18;
    localparam int FLASH_AW = 14;
    localparam int FLASH_BYTES = 16384;
    localparam logic [15:0] IR_FLASH_CTRL = 16'h0082;
    localparam logic [15:0] IR_FLASH_SCALE = 16'h0085;
    localparam logic [15:0] IR_RESET = 16'h0004;
    localparam logic [15:0] IR_CAPTURE = 16'h0001;
    // ------------------------------------------------------------
    // field positions, modes, reset values
    // ------------------------------------------------------------
    localparam int OP_MSB = 19;
    localparam int OP_LSB = 18;
    localparam int BYTE_LSB = 10;
    localparam int ADDR_LSB = 2;
    localparam int WM_LSB = 4;
    localparam logic [3:0] WM_PROGRAM = 4'h1;
    localparam logic [3:0] WM_ERASE = 4'h2;
    localparam logic [3:0] RM_FETCH = 4'h1;
    localparam logic [3:0] RM_FETCH_INC = 4'h2;
    localparam logic [7:0] ERASE_KEY = 8'hA5;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SCALE_RESET = 8'h00;
    localparam logic [8:0] SECTOR_LAST = 9'h1FF;

    typedef enum logic [1:0] {SEL_CTRL, SEL_DATA, SEL_ADDR, SEL_SCALE} jif_sel_type;

    typedef enum logic [15:0] {
        TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SELDR = 16'h0004,
        TAP_CAPDR = 16'h0008, TAP_SHDR = 16'h0010, TAP_EX1DR = 16'h0020,
        TAP_PDR = 16'h0040, TAP_EX2DR = 16'h0080, TAP_UPDR = 16'h0100,
        TAP_SELIR = 16'h0200, TAP_CAPIR = 16'h0400, TAP_SHIR = 16'h0800,
        TAP_EX1IR = 16'h1000, TAP_PIR = 16'h2000, TAP_EX2IR = 16'h4000,
        TAP_UPIR = 16'h8000
    } jif_tap_type;

    typedef enum logic [2:0] {ENG_IDLE = 3'h1, ENG_WAIT = 3'h2, ENG_ERASE = 3'h4} jif_eng_type;

    typedef struct packed {
        logic start;
        logic wr;
        jif_sel_type sel;
        logic [PAY_W-1:0] payload;
    } jif_req_type;

    typedef struct packed {
        logic busy;
        logic [PAY_W-1:0] result;
    } jif_rsp_type;
endpackage

// file: rtl/jif_top.sv
// test port front end: tap controller, indirect data register, flash engine
// assumes the test clock is slow enough to be sampled by the core clock
//
// Summary of operation
// - host picks a flash register by instruction, then shifts an operation in
// - command word: operation code in bits 19:18, write payload in 17:0
// - operation 0x is poll, 10 is read, 11 is write
// - poll captures the output word but performs no update action
// - read fetches the selected register, launchable with two shifted bits
// - write stores the payload; narrower registers need fewer shifts
// - captured word: zero on top, 18-bit result, busy at bit 0
// - busy rises at launch and falls when the operation completes
// - read and write commands are ignored while busy is high
// - command shifted during the poll scan starts once busy is seen low
// - results are right-aligned above busy; a byte needs nine shifts
// - codes 0x0082..0x0084 select control, data and address registers
// - code 0x0085 selects the scale register that times flash operations
module jif_top import jif_pkg::*; (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE
);
    typedef struct packed {
        logic [2:0] tck_sync;
        logic [1:0] tms_sync;
        logic [1:0] tdi_sync;
        jif_tap_type tap;
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] ir_sh;
        logic [DR_W-1:0] dr;
        logic cap_busy;
        logic tdo;
        logic tdo_oe;
        jif_req_type req;
    } jif_top_state_type;

    localparam jif_top_state_type ST_RST = '{tck_sync: '0, tms_sync: '0, tdi_sync: '0,
        tap: TAP_TLR, ir: IR_RESET, ir_sh: IR_RESET, dr: '0, cap_busy: 1'b0,
        tdo: 1'b0, tdo_oe: 1'b0, req: '0};

    jif_top_state_type st_ff, nxt_st;
    jif_rsp_type rsp;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic flash_ir;
    jif_sel_type sel_w;
    logic [IR_W-1:0] ir_off;

    // ------------------------------------------------------------
    // pin sampling and decode
    // ------------------------------------------------------------
    // edges come from the second and third stages only; the first is left alone
    assign tck_rise = st_ff.tck_sync[1] && !st_ff.tck_sync[2];
    assign tck_fall = !st_ff.tck_sync[1] && st_ff.tck_sync[2];
    assign tms = st_ff.tms_sync[1];
    assign tdi = st_ff.tdi_sync[1];
    assign ir_off = st_ff.ir - IR_FLASH_CTRL;
    assign flash_ir = (st_ff.ir >= IR_FLASH_CTRL) && (st_ff.ir <= IR_FLASH_SCALE);
    assign sel_w = jif_sel_type'(ir_off[1:0]);
    assign TDO = st_ff.tdo;
    assign TDO_OE = st_ff.tdo_oe;

    // ------------------------------------------------------------
    // tap state transitions
    // ------------------------------------------------------------
    function automatic jif_tap_type tap_next(input jif_tap_type s, input logic m);
        case (s)
            TAP_TLR: tap_next = m ? TAP_TLR : TAP_RTI;
            TAP_RTI: tap_next = m ? TAP_SELDR : TAP_RTI;
            TAP_SELDR: tap_next = m ? TAP_SELIR : TAP_CAPDR;
            TAP_CAPDR: tap_next = m ? TAP_EX1DR : TAP_SHDR;
            TAP_SHDR: tap_next = m ? TAP_EX1DR : TAP_SHDR;
            TAP_EX1DR: tap_next = m ? TAP_UPDR : TAP_PDR;
            TAP_PDR: tap_next = m ? TAP_EX2DR : TAP_PDR;
            TAP_EX2DR: tap_next = m ? TAP_UPDR : TAP_SHDR;
            TAP_UPDR: tap_next = m ? TAP_SELDR : TAP_RTI;
            TAP_SELIR: tap_next = m ? TAP_TLR : TAP_CAPIR;
            TAP_CAPIR: tap_next = m ? TAP_EX1IR : TAP_SHIR;
            TAP_SHIR: tap_next = m ? TAP_EX1IR : TAP_SHIR;
            TAP_EX1IR: tap_next = m ? TAP_UPIR : TAP_PIR;
            TAP_PIR: tap_next = m ? TAP_EX2IR : TAP_PIR;
            TAP_EX2IR: tap_next = m ? TAP_UPIR : TAP_SHIR;
            TAP_UPIR: tap_next = m ? TAP_SELDR : TAP_RTI;
            default: tap_next = TAP_TLR;
        endcase
    endfunction

    // ------------------------------------------------------------
    // scan actions on test clock edges
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tck_sync = {st_ff.tck_sync[1:0], TCK};
        nxt_st.tms_sync = {st_ff.tms_sync[0], TMS};
        nxt_st.tdi_sync = {st_ff.tdi_sync[0], TDI};
        nxt_st.req.start = 1'b0;
        if (tck_rise) begin
            nxt_st.tap = tap_next(st_ff.tap, tms);
            case (st_ff.tap)
                TAP_TLR: begin
                    nxt_st.ir = IR_RESET;
                end
                TAP_CAPDR: begin
                    // busy at bit 0 lets a one-bit scan poll
                    nxt_st.dr = flash_ir ? {1'b0, rsp.result, rsp.busy} : '0;
                    nxt_st.cap_busy = rsp.busy;
                end
                TAP_SHDR: begin
                    // short scans leave the shifted bits left-aligned at the top
                    if (flash_ir) begin
                        nxt_st.dr = {tdi, st_ff.dr[DR_W-1:1]};
                    end else begin
                        nxt_st.dr = {{(DR_W-1){1'b0}}, tdi};
                    end
                end
                TAP_UPDR: begin
                    // poll (top bit clear) and commands seen during busy do nothing
                    if (flash_ir && st_ff.dr[OP_MSB] && !st_ff.cap_busy && !rsp.busy) begin
                        nxt_st.req.start = 1'b1;
                        nxt_st.req.wr = st_ff.dr[OP_LSB];
                        nxt_st.req.sel = sel_w;
                        nxt_st.req.payload = st_ff.dr[PAY_W-1:0];
                    end
                end
                TAP_CAPIR: begin
                    nxt_st.ir_sh = IR_CAPTURE;
                end
                TAP_SHIR: begin
                    nxt_st.ir_sh = {tdi, st_ff.ir_sh[IR_W-1:1]};
                end
                TAP_UPIR: begin
                    nxt_st.ir = st_ff.ir_sh;
                end
                default: begin
                end
            endcase
        end
        // output changes on the falling test clock edge, as the host expects
        if (tck_fall) begin
            nxt_st.tdo = (st_ff.tap == TAP_SHIR) ? st_ff.ir_sh[0] : st_ff.dr[0];
            nxt_st.tdo_oe = (st_ff.tap == TAP_SHIR) || (st_ff.tap == TAP_SHDR);
        end
    end

    // ------------------------------------------------------------
    // state register and engine
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    jif_flash_engine u_engine (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .req(st_ff.req),
        .rsp(rsp)
    );

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    sequence s_update_cmd;
        tck_rise && st_ff.tap == TAP_UPDR && flash_ir && st_ff.dr[OP_MSB];
    endsequence

    chk_poll_quiet: assert property (tck_rise && st_ff.tap == TAP_UPDR && !st_ff.dr[OP_MSB]
        |=> !st_ff.req.start)
        else $error("poll launched an operation");
    chk_busy_ignore: assert property (s_update_cmd ##0 st_ff.cap_busy |=> !st_ff.req.start)
        else $error("command accepted while busy");
    chk_cmd_launch: assert property (s_update_cmd ##0 (!st_ff.cap_busy && !rsp.busy)
        |=> st_ff.req.start && st_ff.req.sel == $past(sel_w)
        && st_ff.req.wr == $past(st_ff.dr[OP_LSB]))
        else $error("queued command not launched");
    chk_capture_word: assert property (tck_rise && st_ff.tap == TAP_CAPDR && flash_ir
        |=> !st_ff.dr[DR_W-1] && st_ff.dr[0] == $past(rsp.busy)
        && st_ff.dr[PAY_W:1] == $past(rsp.result))
        else $error("captured word malformed");
    chk_launch_busy: assert property (st_ff.req.start |=> rsp.busy)
        else $error("busy missing after launch");
endmodule // jif_top

// file: bench/jif_host.sv
// host model of the test port: walks the tap controller and shifts scans
// assumes the device samples tck, tms and tdi with the same core clock
module jif_host (
    input wire logic clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    // stays high only if the output enable stood during every shift and fell after it
    logic oe_shift = 1'b0;

    // ------------------------------------------------------------
    // pin driving
    // ------------------------------------------------------------
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one test clock: pins move with the fall, tdo is read at the next fall
    // because it stands until three core clocks after that fall
    task automatic cyc(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clk);
        tck <= 1'b1;
        repeat (4) @(posedge clk);
        tck <= 1'b0;
        o = tdo;
    endtask

    // one scan from idle back to idle, n bits of v sent lsb first
    // tck stands low between scans; tdi toggles whenever it is not shifted
    task automatic scan(input logic ir, input int n, input logic [19:0] v,
                        output logic [19:0] got);
        logic o;
        got = '0;
        oe_shift = 1'b1;
        cyc(1'b1, ~tdi, o);
        if (ir) cyc(1'b1, ~tdi, o);
        cyc(1'b0, ~tdi, o);
        cyc(1'b0, ~tdi, o);
        for (int i = 0; i < n; i++) begin
            cyc(i == n - 1, v[i], o);
            got[i] = o;
            oe_shift = oe_shift & tdo_oe;
        end
        cyc(1'b1, ~tdi, o);
        oe_shift = oe_shift & !tdo_oe;
        cyc(1'b0, ~tdi, o);
    endtask
endmodule // jif_host

// file: bench/testbench.sv
// self-checking bench: host model drives the test port, a reference model
// of the indirect registers and flash predicts every read result
module testbench import jif_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] IR_DATA = 16'h0083;
    localparam logic [15:0] IR_ADDR = 16'h0084;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe, b;
    logic [19:0] g;
    int seed = 32'h50108229;
    int n_mismatch = 0;
    int cmp_count = 0;
    int m_ctrl, m_scale, m_addr, m_data, a, k;
    logic [7:0] mem [int];
    logic [15:0] cur_ir = IR_RESET;

    always #25 core_clk = ~core_clk;

    jif_top uut (.CORE_CLK(core_clk), .RESETN(resetn), .TCK(tck), .TMS(tms), .TDI(tdi),
                 .TDO(tdo), .TDO_OE(tdo_oe));
    jif_host host (.clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
                   .tdo_oe(tdo_oe));

    // ------------------------------------------------------------
    // compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk_reg(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({17'h0, got}, {17'h0, exp});
    endtask
    task automatic results;
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // host operations with the reference model
    // ------------------------------------------------------------
    // instruction only changes between operations, never mid-operation
    task automatic sel(input logic [15:0] ir);
        if (ir != cur_ir) begin
            host.scan(1'b1, 16, {4'h0, ir}, g);
            chk_reg({2'b00, g[15:0]}, 18'h1);
            chk_bit(host.oe_shift, 1'b1);
            cur_ir = ir;
        end
    endtask
    // single-bit polls until busy reads low; a stuck busy shows as mismatch
    task automatic wait_idle;
        k = 0;
        do begin
            host.scan(1'b0, 1, 20'h0, g);
            k++;
        end while (g[0] !== 1'b0 && k < 300);
        chk_bit(g[0], 1'b0);
    endtask
    // short registers take fewer shifts: op bits follow the payload
    task automatic wr(input logic [15:0] ir, input int w, input int val);
        sel(ir);
        host.scan(1'b0, w + 2, 20'(val) | (20'h3 << w), g);
        wait_idle();
        case (ir)
            IR_FLASH_CTRL: m_ctrl = val;
            IR_FLASH_SCALE: m_scale = val;
            IR_ADDR: m_addr = val;
            default: begin
                m_data = val;
                if (m_ctrl[7:4] == 1) begin
                    mem[m_addr % 16384] = 8'(val);
                    m_addr = (m_addr + 1) % 65536;
                end else if (m_ctrl[7:4] == 2 && val == 8'hA5) begin
                    for (int i = 0; i < 512; i++) mem[(m_addr % 16384) / 512 * 512 + i] = 8'hFF;
                end
            end
        endcase
    endtask
    task automatic rd(input logic [15:0] ir, input int w);
        int e;
        case (ir)
            IR_FLASH_CTRL: e = m_ctrl;
            IR_FLASH_SCALE: e = m_scale;
            IR_ADDR: e = m_addr;
            default: begin
                e = m_data;
                if (m_ctrl[3:0] == 1 || m_ctrl[3:0] == 2) e = mem[m_addr % 16384];
                if (m_ctrl[3:0] == 2) m_addr = (m_addr + 1) % 65536;
            end
        endcase
        sel(ir);
        host.scan(1'b0, 2, 20'h2, g);
        wait_idle();
        host.scan(1'b0, w + 1, 20'h0, g);
        chk_bit(g[0], 1'b0);
        chk_bit(host.oe_shift, 1'b1);
        chk_reg(18'((g >> 1) & ((1 << w) - 1)), 18'(e));
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        m_ctrl = 0;
        m_scale = 0;
        m_addr = 0;
        m_data = 0;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        host.cyc(1'b0, 1'b0, b);
        rd(IR_FLASH_CTRL, 8);
        rd(IR_FLASH_SCALE, 8);
        rd(IR_DATA, 8);
        for (int i = 0; i < 3; i++) begin
            wr(IR_FLASH_CTRL, 8, $random(seed) & 8'hFF);
            host.scan(1'b0, 20, 20'h40000 | ($random(seed) & 20'h3FFFF), g);
            rd(IR_FLASH_CTRL, 8);
            wr(IR_FLASH_SCALE, 8, $random(seed) & 8'h0F);
            rd(IR_FLASH_SCALE, 8);
        end
        // erase one sector, program three bytes, then a wrong key
        a = ($random(seed) & 16'h3E00) | 16'h0010;
        wr(IR_ADDR, 16, a);
        wr(IR_FLASH_CTRL, 8, 8'h20);
        wr(IR_DATA, 8, 8'hA5);
        wr(IR_ADDR, 16, a);
        wr(IR_FLASH_CTRL, 8, 8'h12);
        for (int i = 0; i < 3; i++) wr(IR_DATA, 8, $random(seed) & 8'hFF);
        rd(IR_ADDR, 16);
        wr(IR_FLASH_CTRL, 8, 8'h22);
        wr(IR_DATA, 8, 8'h5B);
        wr(IR_ADDR, 16, a);
        for (int i = 0; i < 4; i++) rd(IR_DATA, 8);
        rd(IR_ADDR, 16);
        wr(IR_FLASH_CTRL, 8, 8'h01);
        rd(IR_DATA, 8);
        rd(IR_ADDR, 16);
        wr(IR_FLASH_CTRL, 8, 8'h00);
        wr(IR_DATA, 8, $random(seed) & 8'hFF);
        rd(IR_DATA, 8);
        // slow operations: a command while busy is dropped, a queued one starts
        wr(IR_FLASH_SCALE, 8, 8'hFF);
        sel(IR_FLASH_CTRL);
        host.scan(1'b0, 10, 20'h35A, g);
        host.scan(1'b0, 10, 20'h33C, g);
        chk_bit(g[0], 1'b1);
        m_ctrl = 8'h5A;
        wait_idle();
        rd(IR_FLASH_CTRL, 8);
        host.scan(1'b0, 10, 20'h396, g);
        k = 0;
        do begin
            host.scan(1'b0, 10, 20'h3C3, g);
            k++;
        end while (g[0] !== 1'b0 && k < 20);
        m_ctrl = 8'hC3;
        wait_idle();
        rd(IR_FLASH_CTRL, 8);
        results();
    end

    // watchdog: the sequence needs well under this many core clocks
    initial begin
        repeat (90000) @(posedge core_clk);
        n_mismatch++;
        results();
    end
endmodule // testbench
